/* design/lcl_config_loader.v */
// Purpose: start-up loader for two LED driver controllers, lamp control
// Assumes: 50 MHz clk, sync active-high rst, classic Wishbone slave
// Notes: string voltages are ADC codes already on this clock
//
// How it works
// - Program both controllers before enabling lamp channels
// - First read status registers of both controllers
// - Lamp function from three power inputs, main-beam
// - Faults from binning, thermistor and string voltages
// - Single LED short via channel voltage threshold
// - Boost 55 V: write E7 to reg 07
// - Second controller 11/12 set buck frequencies
// - Current limit field in reg 0E set 11
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "lcl_defs.vh"
module lcl_config_loader (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire pwrBeamIn,
  input wire pwrTurnIn,
  input wire pwrDrlIn,
  input wire mainBeamIn,
  input wire [2:0] binFaultIn,
  input wire [2:0] thermistorHotIn,
  input wire [7:0] beamVolt,
  input wire [7:0] turnVolt,
  input wire spiMiso,
  output wire spiSclk,
  output wire spiMosi,
  output wire spiCsAN,
  output wire spiCsBN,
  output reg beamEnable_r,
  output reg mainBeamChannel_r,
  output reg turnEnable_r,
  output reg drlEnable_r,
  output reg beamFault_r,
  output reg turnFault_r,
  output reg irq_r
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SEND = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;
  localparam [1:0] ST_DONE = 2'd3;
  // Configuration sequence: reads first, then writes in table order
  function [16:0] tblEntry;
    input [5:0] idx;
    begin
      case (idx)
        6'd0: tblEntry = {2'b00, 7'h11, 8'h00};
        6'd1: tblEntry = {2'b00, 7'h12, 8'h00};
        6'd2: tblEntry = {2'b10, 7'h03, 8'h00};
        6'd3: tblEntry = {2'b10, 7'h04, 8'h00};
        6'd4: tblEntry = {2'b10, 7'h05, 8'h00};
        6'd5: tblEntry = {2'b01, 7'h01, 8'h01};
        6'd6: tblEntry = {2'b01, 7'h02, 8'h00};
        6'd7: tblEntry = {2'b01, 7'h03, 8'h00};
        6'd8: tblEntry = {2'b01, 7'h04, 8'h25};
        6'd9: tblEntry = {2'b01, 7'h05, 8'h0F};
        6'd10: tblEntry = {2'b01, 7'h06, 8'hFF};
        6'd11: tblEntry = {2'b01, `LCL_A_BOOST_ADDR, `LCL_A_BOOST_55V};
        6'd12: tblEntry = {2'b01, 7'h08, 8'h0C};
        6'd13: tblEntry = {2'b01, 7'h08, 8'h2B};
        6'd14: tblEntry = {2'b01, 7'h09, 8'h41};
        6'd15: tblEntry = {2'b01, 7'h0B, 8'h0E};
        6'd16: tblEntry = {2'b01, 7'h0A, 8'h02};
        6'd17: tblEntry = {2'b01, 7'h0D, 8'h00};
        6'd18: tblEntry = {2'b01, 7'h0C, 8'h00};
        6'd19: tblEntry = {2'b01, `LCL_A_ILIM_ADDR, `LCL_A_ILIM_VAL};
        6'd20: tblEntry = {2'b01, 7'h0F, 8'h0A};
        6'd21: tblEntry = {2'b01, 7'h10, 8'h99};
        6'd22: tblEntry = {2'b01, 7'h13, 8'h3C};
        6'd23: tblEntry = {2'b01, 7'h14, 8'h2F};
        6'd24: tblEntry = {2'b01, 7'h15, 8'h00};
        6'd25: tblEntry = {2'b01, 7'h16, 8'h44};
        6'd26: tblEntry = {2'b01, 7'h17, 8'h3C};
        6'd27: tblEntry = {2'b11, 7'h00, 8'h00};
        6'd28: tblEntry = {2'b11, 7'h01, 8'h00};
        6'd29: tblEntry = {2'b11, 7'h02, 8'h08};
        6'd30: tblEntry = {2'b11, 7'h06, 8'h8A};
        6'd31: tblEntry = {2'b11, 7'h07, 8'h00};
        6'd32: tblEntry = {2'b11, 7'h09, 8'h07};
        6'd33: tblEntry = {2'b11, 7'h08, 8'h00};
        6'd34: tblEntry = {2'b11, 7'h09, 8'h82};
        6'd35: tblEntry = {2'b11, 7'h08, 8'h00};
        6'd36: tblEntry = {2'b11, 7'h20, 8'h03};
        6'd37: tblEntry = {2'b11, 7'h21, 8'h6A};
        6'd38: tblEntry = {2'b11, 7'h0B, 8'h0E};
        6'd39: tblEntry = {2'b11, 7'h0A, 8'h02};
        6'd40: tblEntry = {2'b11, 7'h0B, 8'h41};
        6'd41: tblEntry = {2'b11, 7'h0A, 8'h00};
        6'd42: tblEntry = {2'b11, 7'h0C, 8'h07};
        6'd43: tblEntry = {2'b11, 7'h0E, 8'h00};
        6'd44: tblEntry = {2'b11, 7'h0D, 8'h40};
        6'd45: tblEntry = {2'b11, 7'h10, 8'h00};
        6'd46: tblEntry = {2'b11, 7'h0F, 8'h40};
        6'd47: tblEntry = {2'b11, `LCL_B_FSW_BEAM, `LCL_B_FSW_BEAM_V};
        6'd48: tblEntry = {2'b11, `LCL_B_FSW_TURN, `LCL_B_FSW_TURN_V};
        6'd49: tblEntry = {2'b11, 7'h1E, 8'h00};
        6'd50: tblEntry = {2'b11, 7'h1F, 8'h00};
        6'd51: tblEntry = {2'b11, 7'h22, 8'h00};
        6'd52: tblEntry = {2'b11, 7'h23, 8'h10};
        6'd53: tblEntry = {2'b11, 7'h24, 8'h00};
        6'd54: tblEntry = {2'b11, 7'h25, 8'h10};
        6'd55: tblEntry = {2'b11, 7'h26, 8'h00};
        6'd56: tblEntry = {2'b11, 7'h27, 8'h00};
        6'd57: tblEntry = {2'b11, 7'h28, 8'h00};
        6'd58: tblEntry = {2'b11, 7'h29, 8'h00};
        6'd59: tblEntry = {2'b11, 7'h2A, 8'h07};
        6'd60: tblEntry = {2'b11, 7'h2B, 8'h07};
        6'd61: tblEntry = {2'b11, 7'h2C, 8'h80};
        default: tblEntry = 17'h00000;
      endcase
    end
  endfunction
  // Two-stage synchronisers for all pin inputs
  reg [9:0] pinMeta_r;
  reg [9:0] pinSync_r;
  reg misoMeta_r;
  reg misoSync_r;
  wire pwrBeam = pinSync_r[0];
  wire pwrTurn = pinSync_r[1];
  wire pwrDrl = pinSync_r[2];
  wire mainBeam = pinSync_r[3];
  wire [2:0] binFault = pinSync_r[6:4];
  wire [2:0] thermHot = pinSync_r[9:7];
  always @(posedge clk) begin
    if (rst) begin
      pinMeta_r <= 10'h000;
      pinSync_r <= 10'h000;
      misoMeta_r <= 1'b0;
      misoSync_r <= 1'b0;
    end else begin
      pinMeta_r <= {thermistorHotIn, binFaultIn, mainBeamIn, pwrDrlIn,
                    pwrTurnIn, pwrBeamIn};
      pinSync_r <= pinMeta_r;
      misoMeta_r <= spiMiso;
      misoSync_r <= misoMeta_r;
    end
  end
  // Sequencer
  reg [1:0] state_r;
  reg [5:0] idx_r;
  reg spiStart_r;
  reg configured_r;
  reg [15:0] rdA_r;
  reg [23:0] rdB_r;
  wire spiDone;
  wire [7:0] spiRx;
  wire [16:0] entry = tblEntry(idx_r);
  reg startReq_r;
  lcl_spi_master uSpi (
    .clk(clk),
    .rst(rst),
    .start(spiStart_r),
    .chipSel(entry[`LCL_CHIP_BIT]),
    .frame(entry[15:0]),
    .misoSync(misoSync_r),
    .done_r(spiDone),
    .rxByte_r(spiRx),
    .sclk_r(spiSclk),
    .mosi_r(spiMosi),
    .csAN_r(spiCsAN),
    .csBN_r(spiCsBN)
  );
  always @(posedge clk) begin
    spiStart_r <= 1'b0;
    if (rst) begin
      state_r <= ST_IDLE;
      idx_r <= 6'd0;
      configured_r <= 1'b0;
      rdA_r <= 16'h0000;
      rdB_r <= 24'h000000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          idx_r <= 6'd0;
          configured_r <= 1'b0;
          state_r <= ST_SEND;
        end
        ST_SEND: begin
          spiStart_r <= 1'b1;
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (spiDone) begin
            if (!entry[`LCL_WR_BIT]) begin
              if (idx_r < `LCL_READ_A_CNT)
                rdA_r <= {rdA_r[7:0], spiRx};
              else
                rdB_r <= {rdB_r[15:0], spiRx};
            end
            if (idx_r == `LCL_TBL_LAST) begin
              state_r <= ST_DONE;
              configured_r <= 1'b1;
            end else begin
              idx_r <= idx_r + 6'd1;
              state_r <= ST_SEND;
            end
          end
        end
        ST_DONE: begin
          if (startReq_r)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  wire doneEvent = (state_r == ST_WAIT) && spiDone &&
                   (idx_r == `LCL_TBL_LAST);
  // Lamp function and fault detection
  reg [7:0] beamMin_r;
  reg [7:0] turnMin_r;
  wire beamShort = beamEnable_r && (beamVolt < beamMin_r);
  wire turnShort = turnEnable_r && (turnVolt < turnMin_r);
  wire anyBin = |binFault;
  wire anyHot = |thermHot;
  always @(posedge clk) begin
    if (rst) begin
      beamEnable_r <= 1'b0;
      mainBeamChannel_r <= 1'b0;
      turnEnable_r <= 1'b0;
      drlEnable_r <= 1'b0;
      beamFault_r <= 1'b0;
      turnFault_r <= 1'b0;
    end else begin
      // Faulted beam and turn channels latch off until the next reconfiguration
      if (!configured_r) begin
        beamFault_r <= 1'b0;
        turnFault_r <= 1'b0;
      end else begin
        if (beamShort || binFault[0]) beamFault_r <= 1'b1;
        if (turnShort || binFault[1]) turnFault_r <= 1'b1;
      end
      beamEnable_r <= configured_r && pwrBeam && !beamFault_r;
      mainBeamChannel_r <= configured_r && pwrBeam && mainBeam &&
                           !beamFault_r;
      turnEnable_r <= configured_r && pwrTurn && !turnFault_r;
      // Daytime light yields to the turn signal on the same side
      drlEnable_r <= configured_r && pwrDrl && !pwrTurn &&
                     !binFault[2] && !thermHot[2];
    end
  end
  // Wishbone slave, interrupts
  reg [`LCL_EV_W-1:0] irqStat_r;
  reg [`LCL_EV_W-1:0] irqEn_r;
  wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wbWr = wbReq && wb_we_i && wb_sel_i[0];
  wire [`LCL_EV_W-1:0] evNow = {anyHot, anyBin, turnShort, beamShort,
                                doneEvent};
  wire [`LCL_EV_W-1:0] clrMask = (wbWr && wb_adr_i == `LCL_REG_IRQ_CLR) ?
                                 wb_dat_i[`LCL_EV_W-1:0] : 5'h00;
  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      irqStat_r <= 5'h00;
      irqEn_r <= 5'h00;
      beamMin_r <= `LCL_BEAM_MIN_RST;
      turnMin_r <= `LCL_TURN_MIN_RST;
      startReq_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
      startReq_r <= wbWr && (wb_adr_i == `LCL_REG_CTRL) && wb_dat_i[0];
      // Set wins over a clear in the same cycle
      irqStat_r <= (irqStat_r & ~clrMask) | evNow;
      irq_r <= |(irqStat_r & irqEn_r);
      if (wbWr && wb_adr_i == `LCL_REG_IRQ_EN)
        irqEn_r <= wb_dat_i[`LCL_EV_W-1:0];
      if (wbWr && wb_adr_i == `LCL_REG_BEAM_MIN)
        beamMin_r <= wb_dat_i[7:0];
      if (wbWr && wb_adr_i == `LCL_REG_TURN_MIN)
        turnMin_r <= wb_dat_i[7:0];
      case (wb_adr_i)
        `LCL_REG_STATUS: wb_dat_o <= {16'h0000, pinSync_r[3:0],
          drlEnable_r, turnEnable_r, mainBeamChannel_r, beamEnable_r,
          turnFault_r, beamFault_r, idx_r};
        `LCL_REG_IRQ_STAT: wb_dat_o <= {27'h0000000, irqStat_r};
        `LCL_REG_IRQ_EN: wb_dat_o <= {27'h0000000, irqEn_r};
        `LCL_REG_BEAM_MIN: wb_dat_o <= {24'h000000, beamMin_r};
        `LCL_REG_TURN_MIN: wb_dat_o <= {24'h000000, turnMin_r};
        `LCL_REG_RD_A: wb_dat_o <= {16'h0000, rdA_r};
        `LCL_REG_RD_B: wb_dat_o <= {8'h00, rdB_r};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule // lcl_config_loader

/* design/lcl_defs.vh */
// Purpose: shared constants of the LED controller configuration loader
// Assumes: 50 MHz clock, classic Wishbone with 32-bit data
// Notes: definitions only
`ifndef LCL_DEFS_VH
`define LCL_DEFS_VH

// Register byte offsets
`define LCL_REG_CTRL     8'h00
`define LCL_REG_STATUS   8'h04
`define LCL_REG_IRQ_STAT 8'h08
`define LCL_REG_IRQ_CLR  8'h0C
`define LCL_REG_IRQ_EN   8'h10
`define LCL_REG_BEAM_MIN 8'h14
`define LCL_REG_TURN_MIN 8'h18
`define LCL_REG_RD_A     8'h1C
`define LCL_REG_RD_B     8'h20

// Interrupt bit positions
`define LCL_EV_DONE      0
`define LCL_EV_BEAM_SHRT 1
`define LCL_EV_TURN_SHRT 2
`define LCL_EV_BIN       3
`define LCL_EV_NTC       4
`define LCL_EV_W         5

// Reset values of the short-detect thresholds (ADC codes)
`define LCL_BEAM_MIN_RST 8'h80
`define LCL_TURN_MIN_RST 8'h40

// Table layout: {chip, write, addr[6:0], data[7:0]}
`define LCL_TBL_LEN      7'd62
`define LCL_TBL_LAST     6'd61
`define LCL_CHIP_BIT     16
`define LCL_WR_BIT       15
`define LCL_READ_A_CNT   6'd2

// Key device settings
`define LCL_A_BOOST_ADDR 7'h07
`define LCL_A_BOOST_55V  8'hE7
`define LCL_A_ILIM_ADDR  7'h0E
`define LCL_A_ILIM_VAL   8'h0F
`define LCL_B_FSW_BEAM   7'h11
`define LCL_B_FSW_BEAM_V 8'h06
`define LCL_B_FSW_TURN   7'h12
`define LCL_B_FSW_TURN_V 8'h07

// SPI timing: serial clock 1 MHz
`define LCL_CLK_HZ       50000000
`define LCL_SCLK_HZ      1000000
`define LCL_HALF_CYC     (`LCL_CLK_HZ / (2 * `LCL_SCLK_HZ))
`define LCL_FRAME_BITS   5'd16
`define LCL_LAST_BIT     5'd15
`endif

/* design/lcl_spi_master.v */
// Purpose: one 16-bit SPI frame, mode 0, MSB first, two chip selects
// Assumes: miso already synchronised by the caller
// Notes: read data is the low byte of the frame shifted in
`timescale 1ns/1ns
`include "lcl_defs.vh"
module lcl_spi_master (
  input wire clk,
  input wire rst,
  input wire start,
  input wire chipSel,
  input wire [15:0] frame,
  input wire misoSync,
  output reg done_r,
  output reg [7:0] rxByte_r,
  output reg sclk_r,
  output reg mosi_r,
  output reg csAN_r,
  output reg csBN_r
);
  // Divider fits in eight bits; cut the 32-bit quotient on purpose
  localparam [31:0] HALF_W = `LCL_HALF_CYC;
  localparam [7:0] HALF = HALF_W[7:0];
  reg busy_r;
  reg [7:0] divCnt_r;
  reg [4:0] bitCnt_r;
  reg [15:0] shift_r;

  always @(posedge clk) begin
    done_r <= 1'b0;
    if (rst) begin
      busy_r <= 1'b0;
      divCnt_r <= 8'h00;
      bitCnt_r <= 5'h00;
      shift_r <= 16'h0000;
      rxByte_r <= 8'h00;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
      csAN_r <= 1'b1;
      csBN_r <= 1'b1;
    end else if (!busy_r) begin
      if (start) begin
        busy_r <= 1'b1;
        divCnt_r <= 8'h00;
        bitCnt_r <= 5'h00;
        shift_r <= frame;
        mosi_r <= frame[15];
        csAN_r <= chipSel;
        csBN_r <= ~chipSel;
      end
    end else if (divCnt_r != HALF - 8'h01) begin
      divCnt_r <= divCnt_r + 8'h01;
    end else begin
      divCnt_r <= 8'h00;
      if (!sclk_r) begin
        sclk_r <= 1'b1;
        rxByte_r <= {rxByte_r[6:0], misoSync};
      end else begin
        sclk_r <= 1'b0;
        if (bitCnt_r == `LCL_LAST_BIT) begin
          busy_r <= 1'b0;
          csAN_r <= 1'b1;
          csBN_r <= 1'b1;
          done_r <= 1'b1;
        end else begin
          bitCnt_r <= bitCnt_r + 5'h01;
          shift_r <= {shift_r[14:0], 1'b0};
          mosi_r <= shift_r[14];
        end
      end
    end
  end
endmodule // lcl_spi_master

/* testbench/lcl_chip_model.sv */
// Purpose: behavioural pair of SPI register chips facing the loader
// Assumes: mode 0, 16-bit frames, MSB first, active-low selects
// Notes: a read returns a fixed mix of chip and address in its last byte
`timescale 1ns/1ns
module lcl_chip_model (
  input wire sclk,
  input wire mosi,
  input wire csAN,
  input wire csBN,
  output wire miso
);
  logic [15:0] shf = 16'h0000;
  logic [4:0] cnt = 5'h00;
  logic [7:0] rb = 8'h00;
  logic misoR = 1'b0;
  logic [16:0] logFrm [0:63];
  int nFrm = 0;
  // A released line shows the inverse, so a stale bit never reads valid
  assign miso = (!csAN || !csBN) ? misoR : ~misoR;
  always @(negedge csAN or negedge csBN) cnt = 5'h00;
  always @(posedge sclk) begin
    if (!csAN || !csBN) begin
      shf = {shf[14:0], mosi};
      cnt = cnt + 5'h01;
      if (cnt == 5'h08) rb = {1'b0, shf[6:0]} ^ (csBN ? 8'h3C : 8'hC3);
    end
  end
  always @(negedge sclk) begin
    if (cnt >= 5'h08 && cnt < 5'h10) misoR <= rb[5'h0F - cnt];
  end
  always @(posedge csAN) begin
    if (cnt == 5'h10 && nFrm < 64) begin
      logFrm[nFrm] = {1'b0, shf};
      nFrm = nFrm + 1;
    end
  end
  always @(posedge csBN) begin
    if (cnt == 5'h10 && nFrm < 64) begin
      logFrm[nFrm] = {1'b1, shf};
      nFrm = nFrm + 1;
    end
  end
endmodule // lcl_chip_model

/* testbench/lcl_loader_asserts.sv */
// Purpose: port-level checks of the configuration loader
// Assumes: one clock, rst synchronous and active high
// Notes: sclk high time is counted in helper logic
`timescale 1ns/1ns
`include "lcl_defs.vh"
module lcl_loader_asserts (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire pwrBeamIn,
  input wire pwrTurnIn,
  input wire spiSclk,
  input wire spiMosi,
  input wire spiCsAN,
  input wire spiCsBN,
  input wire beamEnable_r,
  input wire turnEnable_r,
  input wire beamFault_r,
  input wire irq_r
);
  logic [7:0] hiCnt_r;
  logic [7:0] hiCnt_nxt;
  assign hiCnt_nxt = spiSclk ? hiCnt_r + 8'h01 : 8'h00;
  always @(posedge clk) hiCnt_r <= rst ? 8'h00 : hiCnt_nxt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_CS_ONE: assert property (spiCsAN || spiCsBN)
    else $error("both chip selects low");
  AST_LAMP_AFTER_CFG: assert property (beamEnable_r |-> spiCsAN && spiCsBN)
    else $error("beam lamp on while a frame runs");
  AST_SCLK_IDLE: assert property (spiCsAN && spiCsBN |-> !spiSclk)
    else $error("serial clock moves outside a frame");
  AST_MOSI_HOLD: assert property (spiSclk && $past(spiSclk) |-> $stable(spiMosi))
    else $error("mosi changed while sclk high");
  AST_HALF_PER: assert property ($fell(spiSclk) |-> hiCnt_r == `LCL_HALF_CYC)
    else $error("sclk high time wrong");
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_BEAM_OFF: assert property (!pwrBeamIn [*5] |-> !beamEnable_r)
    else $error("beam enabled without beam power");
  AST_TURN_OFF: assert property (!pwrTurnIn [*5] |-> !turnEnable_r)
    else $error("turn enabled without turn power");
  AST_FAULT_OFF: assert property (beamFault_r |-> ##[0:2] !beamEnable_r)
    else $error("beam stays on after a short");
  cover property ($fell(spiCsBN));
  cover property ($rose(beamFault_r));
  cover property ($rose(irq_r));
endmodule // lcl_loader_asserts
bind lcl_config_loader lcl_loader_asserts u_chk (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .pwrBeamIn(pwrBeamIn), .pwrTurnIn(pwrTurnIn), .spiSclk(spiSclk),
  .spiMosi(spiMosi), .spiCsAN(spiCsAN), .spiCsBN(spiCsBN),
  .beamEnable_r(beamEnable_r), .turnEnable_r(turnEnable_r),
  .beamFault_r(beamFault_r), .irq_r(irq_r));

/* testbench/tb_top.sv */
// Purpose: self-checking bench of the configuration loader
// Assumes: 50 MHz clock, one model of both chips on the SPI side
// Notes: one full configuration run, about 50k cycles
`timescale 1ns/1ns
`include "lcl_defs.vh"
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] datI = 32'h00000000, rd;
  logic pB = 1'b1, pT = 1'b0, pD = 1'b0, mB = 1'b0;
  logic [2:0] bin = 3'h0, hot = 3'h0;
  logic [7:0] bV = 8'hC0, tV = 8'hC0;
  wire [31:0] datO;
  wire ack, sclk, mosi, csA, csB, miso, bEn, mEn, tEn, dEn, bF, tF, irq;
  int n_fail = 0;
  int num_checks = 0;
  localparam logic [15:0] EXP_TBL [0:61] = '{
    16'h1100, 16'h1200, 16'h0300, 16'h0400, 16'h0500,
    16'h8101, 16'h8200, 16'h8300, 16'h8425, 16'h850F, 16'h86FF, 16'h87E7,
    16'h880C, 16'h882B, 16'h8941, 16'h8B0E, 16'h8A02, 16'h8D00, 16'h8C00,
    16'h8E0F, 16'h8F0A, 16'h9099, 16'h933C, 16'h942F, 16'h9500, 16'h9644,
    16'h973C, 16'h8000, 16'h8100, 16'h8208, 16'h868A, 16'h8700, 16'h8907,
    16'h8800, 16'h8982, 16'h8800, 16'hA003, 16'hA16A, 16'h8B0E, 16'h8A02,
    16'h8B41, 16'h8A00, 16'h8C07, 16'h8E00, 16'h8D40, 16'h9000, 16'h8F40,
    16'h9106, 16'h9207, 16'h9E00, 16'h9F00, 16'hA200, 16'hA310, 16'hA400,
    16'hA510, 16'hA600, 16'hA700, 16'hA800, 16'hA900, 16'hAA07, 16'hAB07,
    16'hAC80};
  // Inputs {beam, turn, day, main}, outputs {beamEn, main, turnEn, dayEn}
  localparam logic [3:0] LAMP_IN [0:4] = '{4'h8, 4'h9, 4'h4, 4'h6, 4'h2};
  localparam logic [3:0] LAMP_OUT [0:4] = '{4'h8, 4'hC, 4'h2, 4'h2, 4'h1};
  always #10 clk = ~clk;
  lcl_config_loader DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .pwrBeamIn(pB),
    .pwrTurnIn(pT), .pwrDrlIn(pD), .mainBeamIn(mB), .binFaultIn(bin),
    .thermistorHotIn(hot), .beamVolt(bV), .turnVolt(tV), .spiMiso(miso),
    .spiSclk(sclk), .spiMosi(mosi), .spiCsAN(csA), .spiCsBN(csB),
    .beamEnable_r(bEn), .mainBeamChannel_r(mEn), .turnEnable_r(tEn),
    .drlEnable_r(dEn), .beamFault_r(bF), .turnFault_r(tF), .irq_r(irq));
  lcl_chip_model model (.sclk(sclk), .mosi(mosi), .csAN(csA), .csBN(csB),
    .miso(miso));
  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, datI} <= {2'b11, w, a, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) n_fail++;
    if (i == 20) summarize();
    rd = datO;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, string nm);
    wb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask
  task automatic scnReset;
    rdChk(`LCL_REG_BEAM_MIN, 32'h80, "beamMin");
    rdChk(`LCL_REG_TURN_MIN, 32'h40, "turnMin");
    rdChk(8'h3C, 32'h0, "unmapped");
    wb(1'b1, `LCL_REG_IRQ_EN, 32'h1);
    rdChk(`LCL_REG_IRQ_EN, 32'h1, "irqEn");
    check("beamEnDuringCfg", bEn, 32'h0);
  endtask
  task automatic scnConfig;
    int i;
    for (i = 0; i < 60000 && model.nFrm < 62; i++) @(posedge clk);
    if (i == 60000) n_fail++;
    if (i == 60000) summarize();
    repeat (20) @(posedge clk);
    check("frameCount", model.nFrm, 32'd62);
    for (i = 0; i < 62; i++)
      check("frame", model.logFrm[i], {(i > 1 && i < 5) || i > 26,
        EXP_TBL[i]});
    rdChk(`LCL_REG_IRQ_STAT, 32'h1, "irqStat");
    check("irqDone", irq, 32'h1);
    check("beamEnAfterCfg", bEn, 32'h1);
    rdChk(`LCL_REG_STATUS, 32'h113D, "status");
    rdChk(`LCL_REG_RD_A, 32'h2D2E, "readA");
    rdChk(`LCL_REG_RD_B, 32'hC0C7C6, "readB");
    wb(1'b1, `LCL_REG_IRQ_CLR, 32'h1);
    settle();
    check("irqCleared", irq, 32'h0);
  endtask
  task automatic scnLamp;
    for (int k = 0; k < 5; k++) begin
      {pB, pT, pD, mB} <= LAMP_IN[k];
      settle();
      check("lamps", {bEn, mEn, tEn, dEn}, LAMP_OUT[k]);
    end
  endtask
  task automatic scnFault;
    {pB, pT, pD, mB} <= 4'hC;
    wb(1'b1, `LCL_REG_IRQ_EN, 32'h2);
    bV <= 8'h80;
    settle();
    check("beamAtMin", bF, 32'h0);
    check("irqMasked", irq, 32'h0);
    bV <= 8'h7F;
    settle();
    check("beamShort", {bF, bEn, tF, irq}, 32'h9);
    wb(1'b1, `LCL_REG_TURN_MIN, 32'h90);
    tV <= 8'h8F;
    settle();
    check("turnShort", tF, 32'h1);
    bin <= 3'h4;
    hot <= 3'h4;
    settle();
    rdChk(`LCL_REG_IRQ_STAT, 32'h1E, "faultStat");
    bin <= 3'h0;
    hot <= 3'h0;
    settle();
    wb(1'b1, `LCL_REG_IRQ_CLR, 32'h18);
    rdChk(`LCL_REG_IRQ_STAT, 32'h06, "clearedStat");
    wb(1'b1, `LCL_REG_IRQ_EN, 32'h0);
    settle();
    check("irqOff", irq, 32'h0);
  endtask
  // Restart drops lamps and latched faults, then reads status again
  task automatic scnRestart;
    int i;
    wb(1'b1, `LCL_REG_CTRL, 32'h1);
    settle();
    check("restartLamps", {bEn, mEn, tEn, dEn}, 32'h0);
    check("restartFaults", {bF, tF}, 32'h0);
    for (i = 0; i < 5000 && model.nFrm < 64; i++) @(posedge clk);
    if (i == 5000) n_fail++;
    if (i == 5000) summarize();
    check("rereadFirst", model.logFrm[62], 32'h1100);
    check("rereadSecond", model.logFrm[63], 32'h1200);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    scnReset();
    scnConfig();
    scnLamp();
    scnFault();
    scnRestart();
    summarize();
  end
endmodule // tb_top
